//--- rtl/bpc_pkg.sv
/*
 * bpc_pkg: shared constants and types for the backward path signal codec.
 * assumes both ends run on one 40 MHz clock and exchange 8-bit characters.
 */
package bpc_pkg;
    // ------------------------------------------------------------
    // character framing
    // ------------------------------------------------------------
    localparam int unsigned CHAR_W = 8;
    localparam logic [2:0] UPPER_BITS = 3'h3; // b7=0 b6=1 b5=1
    localparam int unsigned NIB_W = 4;
    // ------------------------------------------------------------
    // primary set low nibble codes
    // ------------------------------------------------------------
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] CODE_CPS_START = 4'ha;
    localparam logic [3:0] CODE_LINE_END = 4'hb;
    localparam logic [3:0] CODE_CONNECTED = 4'hc; // b1 selects metering
    localparam logic [3:0] CODE_TC_START = 4'he;
    localparam logic [3:0] CODE_ESCAPE = 4'hf;
    localparam logic [3:0] CODE_TC_BASE = 4'hc; // b2 clip, b1 no metering
    localparam int unsigned NET_ID_DIGITS = 4;
    // ------------------------------------------------------------
    // user side commands
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BPC_CMD_DIGIT,
        BPC_CMD_CPS_START,
        BPC_CMD_LINE_END,
        BPC_CMD_NET_ID,
        BPC_CMD_CONNECTED,
        BPC_CMD_TRANSIT,
        BPC_CMD_EXTENDED
    } bpc_cmd_e;
    // received character kinds
    typedef enum logic [2:0] {
        BPC_EV_DIGIT,
        BPC_EV_CPS_START,
        BPC_EV_LINE_END,
        BPC_EV_CONNECTED,
        BPC_EV_TC_START,
        BPC_EV_TRANSIT,
        BPC_EV_EXTENDED
    } bpc_ev_e;
    // odd parity over the 8-bit character
    function automatic logic [7:0] bpc_frame(input logic [3:0] nib);
        logic [6:0] low;
        low = {UPPER_BITS, nib};
        return {~(^low), low};
    endfunction
endpackage

//--- rtl/bpc_link_if.sv
/*
 * bpc_link_if: backward signalling path between the signalled-to end
 * (sender) and the preceding end (receiver). assumes one common clock.
 */
`timescale 1ns/1ps
interface bpc_link_if;
    logic [7:0] char_data; // 8-bit character with parity
    logic char_valid; // one-cycle character strobe
    modport sender (output char_data, output char_valid);
    modport receiver (input char_data, input char_valid);
endinterface

//--- rtl/bpc_tx.sv
/*
 * bpc_tx: signalled-to end; turns user commands into framed characters.
 * assumes the link accepts one character per cycle with no back-pressure.
 */
// How it works
// - upper bits always 011
// - b8 gives odd parity
// - nibbles 0..9 are digits
// - 1010 starts call progress code
// - 1011 ends line id, starts net id
// - missing line id sends 1011 alone
// - 1110 starts transit connect indication
// - 1110 always immediately precedes transit indication
// - 1111 escapes to extended set
// - extended char only right after escape
// - extended codes national use only
// - transit: b2 line id, b1 metering
// - after 1110 only 11xx allowed
// - net id is exactly four digits
`timescale 1ns/1ps
module bpc_tx (
    input wire logic ref_clk_i, // 40 MHz clock
    input wire logic resetn_i, // async reset, active low
    input wire logic cmd_valid_i, // command request
    output logic cmd_ready_o, // command accepted this cycle
    input wire bpc_pkg::bpc_cmd_e cmd_i, // command kind
    input wire logic [15:0] cmd_arg_i, // digit, flags or net id digits
    bpc_link_if.sender link // backward path out
);
    // ------------------------------------------------------------
    // sequencing state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_SECOND, ST_NETID} bpc_tx_st_e;
    bpc_tx_st_e st_q;
    logic [3:0] second_q; // nibble sent after a prefix
    logic [15:0] netid_q; // four bcd digits, first in top
    logic [1:0] dcnt_q;

    assign cmd_ready_o = (st_q == ST_IDLE);

    // state and sequence control
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= ST_IDLE;
            second_q <= 4'h0;
            netid_q <= 16'h0000;
            dcnt_q <= 2'h0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (cmd_valid_i) begin
                        if (cmd_i == bpc_pkg::BPC_CMD_TRANSIT) begin
                            st_q <= ST_SECOND;
                            // top bits forced to 11 so no unallocated code follows the marker
                            second_q <= {bpc_pkg::CODE_TC_BASE[3:2], cmd_arg_i[1:0]};
                        end else if (cmd_i == bpc_pkg::BPC_CMD_EXTENDED) begin
                            st_q <= ST_SECOND;
                            second_q <= cmd_arg_i[3:0];
                        end else if (cmd_i == bpc_pkg::BPC_CMD_NET_ID) begin
                            st_q <= ST_NETID;
                            netid_q <= cmd_arg_i;
                            dcnt_q <= 2'h0;
                        end
                    end
                end
                ST_SECOND: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    netid_q <= {netid_q[11:0], 4'h0};
                    dcnt_q <= dcnt_q + 2'h1;
                    if (dcnt_q == 2'(bpc_pkg::NET_ID_DIGITS - 1)) begin
                        st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // character output register
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link.char_valid <= 1'b0;
            link.char_data <= 8'h00;
        end else begin
            link.char_valid <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (cmd_valid_i) begin
                        link.char_valid <= 1'b1;
                        case (cmd_i)
                            bpc_pkg::BPC_CMD_DIGIT: begin
                                // out-of-range digits clamp to 9 so nothing unallocated leaves
                                link.char_data <= bpc_pkg::bpc_frame((cmd_arg_i[3:0] > bpc_pkg::DIGIT_MAX)
                                    ? bpc_pkg::DIGIT_MAX : cmd_arg_i[3:0]);
                            end
                            bpc_pkg::BPC_CMD_CPS_START: link.char_data <= bpc_pkg::bpc_frame(bpc_pkg::CODE_CPS_START);
                            bpc_pkg::BPC_CMD_LINE_END: link.char_data <= bpc_pkg::bpc_frame(bpc_pkg::CODE_LINE_END);
                            bpc_pkg::BPC_CMD_NET_ID: link.char_data <= bpc_pkg::bpc_frame(bpc_pkg::CODE_LINE_END);
                            bpc_pkg::BPC_CMD_CONNECTED: begin
                                link.char_data <= bpc_pkg::bpc_frame({bpc_pkg::CODE_CONNECTED[3:1], cmd_arg_i[0]});
                            end
                            bpc_pkg::BPC_CMD_TRANSIT: link.char_data <= bpc_pkg::bpc_frame(bpc_pkg::CODE_TC_START);
                            default: link.char_data <= bpc_pkg::bpc_frame(bpc_pkg::CODE_ESCAPE);
                        endcase
                    end
                end
                ST_SECOND: begin
                    link.char_valid <= 1'b1;
                    link.char_data <= bpc_pkg::bpc_frame(second_q);
                end
                default: begin
                    link.char_valid <= 1'b1;
                    link.char_data <= bpc_pkg::bpc_frame((netid_q[15:12] > bpc_pkg::DIGIT_MAX)
                        ? bpc_pkg::DIGIT_MAX : netid_q[15:12]);
                end
            endcase
        end
    end
endmodule

//--- rtl/bpc_rx.sv
/*
 * bpc_rx: preceding end; decodes backward path characters into events.
 * assumes at most one character per cycle, no flow control needed.
 */
`timescale 1ns/1ps
module bpc_rx (
    input wire logic ref_clk_i, // 40 MHz clock
    input wire logic resetn_i, // async reset, active low
    bpc_link_if.receiver link, // backward path in
    output logic ev_valid_o, // one-cycle decoded event
    output bpc_pkg::bpc_ev_e ev_kind_o, // event kind
    output logic [3:0] ev_nib_o, // low nibble of the character
    output logic ev_clip_o, // transit: line id required
    output logic ev_no_meter_o, // connected or transit: no metering
    output logic err_o // one-cycle protocol error
);
    // ------------------------------------------------------------
    // decoding position
    // ------------------------------------------------------------
    typedef enum logic [1:0] {POS_PRIMARY, POS_TRANSIT, POS_EXTENDED} bpc_pos_e;
    bpc_pos_e pos_q;
    logic [3:0] nib;
    logic par_ok;
    logic frame_ok;

    assign nib = link.char_data[3:0];
    assign par_ok = ^link.char_data;
    assign frame_ok = (link.char_data[6:4] == bpc_pkg::UPPER_BITS);

    // position tracking; a bad character still consumes the position
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pos_q <= POS_PRIMARY;
        end else if (link.char_valid) begin
            if (pos_q != POS_PRIMARY) begin
                pos_q <= POS_PRIMARY;
            end else if (nib == bpc_pkg::CODE_TC_START) begin
                pos_q <= POS_TRANSIT;
            end else if (nib == bpc_pkg::CODE_ESCAPE) begin
                pos_q <= POS_EXTENDED;
            end
        end
    end

    // decode and flag
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ev_valid_o <= 1'b0;
            ev_kind_o <= bpc_pkg::BPC_EV_DIGIT;
            ev_nib_o <= 4'h0;
            ev_clip_o <= 1'b0;
            ev_no_meter_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ev_valid_o <= 1'b0;
            err_o <= 1'b0;
            if (link.char_valid) begin
                ev_nib_o <= nib;
                ev_clip_o <= nib[1];
                ev_no_meter_o <= nib[0];
                if (!par_ok || !frame_ok) begin
                    err_o <= 1'b1;
                end else if (pos_q == POS_TRANSIT) begin
                    if (nib[3:2] == bpc_pkg::CODE_TC_BASE[3:2]) begin
                        ev_valid_o <= 1'b1;
                        ev_kind_o <= bpc_pkg::BPC_EV_TRANSIT;
                    end else begin
                        err_o <= 1'b1;
                    end
                end else if (pos_q == POS_EXTENDED) begin
                    // national-use codes are passed up raw
                    ev_valid_o <= 1'b1;
                    ev_kind_o <= bpc_pkg::BPC_EV_EXTENDED;
                end else if (nib <= bpc_pkg::DIGIT_MAX) begin
                    ev_valid_o <= 1'b1;
                    ev_kind_o <= bpc_pkg::BPC_EV_DIGIT;
                end else if (nib == bpc_pkg::CODE_CPS_START) begin
                    ev_valid_o <= 1'b1;
                    ev_kind_o <= bpc_pkg::BPC_EV_CPS_START;
                end else if (nib == bpc_pkg::CODE_LINE_END) begin
                    ev_valid_o <= 1'b1;
                    ev_kind_o <= bpc_pkg::BPC_EV_LINE_END;
                end else if (nib[3:1] == bpc_pkg::CODE_CONNECTED[3:1]) begin
                    ev_valid_o <= 1'b1;
                    ev_kind_o <= bpc_pkg::BPC_EV_CONNECTED;
                end else if (nib == bpc_pkg::CODE_TC_START) begin
                    ev_valid_o <= 1'b1;
                    ev_kind_o <= bpc_pkg::BPC_EV_TC_START;
                end
                // escape 1111 only moves the position, no event
            end
        end
    end
endmodule

//--- verif/bpc_link_asserts.sv
/*
 * bpc_link_asserts: wire checks on the backward path between the two ends.
 * assumes one clock, and tb_top instantiating it beside the joined link.
 */
`timescale 1ns/1ps
module bpc_link_asserts (
    input wire logic ref_clk_i, // link clock
    input wire logic resetn_i, // async reset, active low
    input wire logic [7:0] char_data, // character on the wire
    input wire logic char_valid // character strobe
);
    // ----------------------------------------
    // decode position, as a receiver sees it
    // ----------------------------------------
    logic tc_q; // last char was a transit start marker
    logic esc_q; // last char was an escape
    wire logic prim = !tc_q && !esc_q;
    // moves only on a strobe, so gaps keep the position
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tc_q <= 1'b0;
            esc_q <= 1'b0;
        end else if (char_valid) begin
            tc_q <= prim && char_data[3:0] == 4'he;
            esc_q <= prim && char_data[3:0] == 4'hf;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_UPPER_BITS: assert property (char_valid |-> char_data[6:4] == 3'b011)
        else $error("upper bits not 011");
    AST_ODD_PARITY: assert property (char_valid |-> ^char_data == 1'b1)
        else $error("even parity on the wire");
    AST_TC_FOLLOWS: assert property (char_valid && prim && char_data[3:0] == 4'he |=> char_valid)
        else $error("transit marker not followed at once");
    AST_TC_CODE: assert property (char_valid && tc_q |-> char_data[3:2] == 2'b11)
        else $error("unallocated code after transit marker");
    AST_TC_ADJACENT: assert property (char_valid && tc_q |-> $past(char_valid))
        else $error("transit indication not right after marker");
    AST_ESC_FOLLOWS: assert property (char_valid && prim && char_data[3:0] == 4'hf |=> char_valid)
        else $error("escape not followed at once");
    AST_EXT_ADJACENT: assert property (char_valid && esc_q |-> $past(char_valid))
        else $error("extended char not right after escape");
    AST_HOLD: assert property (!char_valid |-> $stable(char_data))
        else $error("character changed between strobes");
endmodule

//--- verif/tb_top.sv
/*
 * tb_top: drives the sender's commands, and a faulty far end on a second
 * link; compares decoded events. assumes the rtl/ files are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_i, resetn_i, cmd_valid, cmd_ready;
    bpc_pkg::bpc_cmd_e cmd;
    logic [15:0] cmd_arg;
    logic [1:0] ev_valid, ev_clip, ev_nm, err;
    bpc_pkg::bpc_ev_e ev_kind [2];
    logic [3:0] ev_nib [2];
    logic [9:0] got[$], exp[$];
    logic [3:0] xv [4] = '{4'h0, 4'h8, 4'he, 4'hf};
    int err_total = 0;
    int n_checks = 0;
    int last_wait = 0; // cycles the last send waited for ready
    // ----------------------------------------
    // ends: lk[0] joins tx to rx, lk[1] is driven by the bench
    // ----------------------------------------
    bpc_link_if lk [2] ();
    bpc_tx u_bpc_tx (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_i(cmd), .cmd_arg_i(cmd_arg), .link(lk[0]));
    for (genvar i = 0; i < 2; i++) begin : g_rx
        bpc_rx u_bpc_rx (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link(lk[i]), .ev_valid_o(ev_valid[i]),
            .ev_kind_o(ev_kind[i]), .ev_nib_o(ev_nib[i]), .ev_clip_o(ev_clip[i]), .ev_no_meter_o(ev_nm[i]),
            .err_o(err[i]));
    end
    bpc_link_asserts u_bpc_link_asserts (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .char_data(lk[0].char_data), .char_valid(lk[0].char_valid));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // flags kept only where they mean something, so don't-care bits never mismatch
    function automatic logic [9:0] pack(bpc_pkg::bpc_ev_e k, logic [3:0] n, logic c, logic m);
        return {1'b0, k, n, k == bpc_pkg::BPC_EV_TRANSIT && c,
            (k == bpc_pkg::BPC_EV_TRANSIT || k == bpc_pkg::BPC_EV_CONNECTED) && m};
    endfunction
    function automatic logic [7:0] fr(input logic [3:0] n);
        return {~^{3'b011, n}, 3'b011, n};
    endfunction
    // both links share one queue; only one carries traffic at a time
    // sampled mid-cycle, where the registered one-cycle pulses have settled
    always @(negedge ref_clk_i) begin
        for (int i = 0; i < 2; i++) begin
            if (err[i] === 1'b1) got.push_back(10'h200);
            else if (ev_valid[i] === 1'b1) got.push_back(pack(ev_kind[i], ev_nib[i], ev_clip[i], ev_nm[i]));
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic end_sim();
        if (err_total == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic ex(input bpc_pkg::bpc_ev_e k, input logic [3:0] n);
        exp.push_back(pack(k, n, n[1], n[0]));
    endtask
    // valid stays up on return; each call drives it high again with its own command
    task automatic send(input bpc_pkg::bpc_cmd_e c, input logic [15:0] a);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd = c;
        cmd_arg = a;
        while (cmd_ready !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        last_wait = n;
        check("cmd ready", 16'(n < 20), 16'h1);
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic put(input logic [7:0] d);
        lk[1].char_valid = 1'b1;
        lk[1].char_data = d;
        @(posedge ref_clk_i);
        #1;
    endtask
    task automatic drain();
        repeat (6) @(posedge ref_clk_i);
        #1;
        check("event count", 16'(got.size()), 16'(exp.size()));
        while (exp.size() > 0 && got.size() > 0) check("event", got.pop_front(), exp.pop_front());
        exp.delete();
        got.delete();
    endtask
    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // tests take some 80 cycles
    initial begin
        #(25 * 2000);
        check("watchdog", 16'h1, 16'h0);
        end_sim();
    end
    initial begin
        resetn_i = 1'b0;
        cmd_valid = 1'b0;
        cmd = bpc_pkg::BPC_CMD_DIGIT;
        cmd_arg = 16'h0;
        lk[1].char_valid = 1'b0;
        lk[1].char_data = 8'h00;
        repeat (20) @(posedge ref_clk_i);
        #1;
        resetn_i = 1'b1;
        for (int i = 0; i < 11; i++) begin
            send(bpc_pkg::BPC_CMD_DIGIT, (i == 10) ? 16'h000c : 16'(i));
            ex(bpc_pkg::BPC_EV_DIGIT, (i == 10) ? 4'h9 : 4'(i));
        end
        send(bpc_pkg::BPC_CMD_CPS_START, 16'h0);
        ex(bpc_pkg::BPC_EV_CPS_START, 4'ha);
        send(bpc_pkg::BPC_CMD_LINE_END, 16'h0);
        ex(bpc_pkg::BPC_EV_LINE_END, 4'hb);
        send(bpc_pkg::BPC_CMD_NET_ID, 16'h2049);
        ex(bpc_pkg::BPC_EV_LINE_END, 4'hb);
        foreach (xv[i]) ex(bpc_pkg::BPC_EV_DIGIT, 4'((16'h2049 >> (12 - 4 * i)) & 16'h000f));
        for (int i = 0; i < 4; i++) begin
            send(bpc_pkg::BPC_CMD_TRANSIT, 16'(i));
            check("ready gap", 16'(last_wait), (i == 0) ? 16'(bpc_pkg::NET_ID_DIGITS) : 16'h1);
            ex(bpc_pkg::BPC_EV_TC_START, 4'he);
            ex(bpc_pkg::BPC_EV_TRANSIT, 4'hc | 4'(i));
            send(bpc_pkg::BPC_CMD_CONNECTED, 16'(i & 1));
            check("ready gap", 16'(last_wait), 16'h1);
            ex(bpc_pkg::BPC_EV_CONNECTED, 4'hc | 4'(i & 1));
            send(bpc_pkg::BPC_CMD_EXTENDED, 16'(xv[i]));
            check("ready gap", 16'(last_wait), 16'h0);
            ex(bpc_pkg::BPC_EV_EXTENDED, xv[i]);
        end
        send(bpc_pkg::BPC_CMD_DIGIT, 16'h7);
        ex(bpc_pkg::BPC_EV_DIGIT, 4'h7);
        cmd_valid = 1'b0;
        drain();
        // faulty far end: bad chars flag an error yet still move the position
        put(fr(4'h5) ^ 8'h80);
        put(8'h45);
        put(fr(4'he));
        put(fr(4'hb));
        put(fr(4'hf));
        put(fr(4'he));
        put(fr(4'he));
        put(fr(4'hd));
        put(fr(4'hd));
        lk[1].char_valid = 1'b0;
        lk[1].char_data = ~lk[1].char_data;
        exp = '{10'h200, 10'h200};
        ex(bpc_pkg::BPC_EV_TC_START, 4'he);
        exp.push_back(10'h200);
        ex(bpc_pkg::BPC_EV_EXTENDED, 4'he);
        ex(bpc_pkg::BPC_EV_TC_START, 4'he);
        ex(bpc_pkg::BPC_EV_TRANSIT, 4'hd);
        ex(bpc_pkg::BPC_EV_CONNECTED, 4'hd);
        drain();
        end_sim();
    end
endmodule
